// File: rtl/uoe_pkg.sv
package uoe_pkg;
	// ****************************************
	// Register addresses
	// ****************************************
	localparam logic [7:0] UOE_IDX_CTRL_LOW = 8'h14;
	localparam logic [7:0] UOE_IDX_CTRL_HIGH = 8'h15;
	localparam logic [7:0] UOE_IDX_COUNT_LOW = 8'h16;
	localparam logic [7:0] UOE_IDX_COUNT_HIGH = 8'h17;
	localparam logic [7:0] UOE_SFR_ENERGY = 8'hb2;
	localparam logic [7:0] UOE_SFR_CONFIG = 8'hb5;
	localparam logic [7:0] UOE_SFR_ADDR_PORT = 8'h96;
	localparam logic [7:0] UOE_SFR_DATA_PORT = 8'h97;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int UOE_BIT_OUT_PACKET_READY = 0;
	localparam int UOE_BIT_FULL = 1;
	localparam int UOE_BIT_OVR = 2;
	localparam int UOE_BIT_ERR = 3;
	localparam int UOE_BIT_ISO = 6;
	localparam int UOE_BIT_DBL = 7;
	localparam int UOE_BIT_SENSE_EN = 7;
	localparam int UOE_BIT_IRQ_EN = 6;
	localparam int UOE_BIT_EVENT = 5;
	localparam logic [2:0] UOE_CLKSEL_RESET = 3'h7;
	localparam int UOE_COUNT_W = 10;
	typedef enum logic [2:0] {
		UOE_CLK_HF = 3'b000,
		UOE_CLK_HF_DIV8 = 3'b001,
		UOE_CLK_EXT_DIV1 = 3'b010,
		UOE_CLK_EXT_DIV2 = 3'b011,
		UOE_CLK_EXT_DIV3 = 3'b100,
		UOE_CLK_EXT_DIV4 = 3'b101,
		UOE_CLK_LF = 3'b110,
		UOE_CLK_OFF = 3'b111
	} uoe_clksel_t;
	// Packet receive report from the serial engine
	typedef struct packed {
		logic done;
		logic crc_err;
		logic stuff_err;
		logic [UOE_COUNT_W-1:0] count;
	} uoe_rx_pkt_t;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] rdata;
		logic out_packet_ready;
		logic err;
		logic ovr;
		logic dbl;
		logic iso;
		logic [1:0] pkts;
		logic fifo_full;
		logic [UOE_COUNT_W-1:0] count;
		logic sense_en;
		logic irq_en;
		logic event_flag;
		logic [2:0] clksel;
		logic [3:0] src_en;
		logic [2:0] div_cnt;
		logic usb_tick;
		logic irq;
		logic [1:0] sense_sync;
		logic sense_prev;
	} uoe_state_t;
endpackage

// File: rtl/uoe_top.sv
`timescale 1ns/100ps
// Summary of operation
// - In isochronous mode a received packet with CRC or bit-stuff error sets the error flag.
// - The error flag clears when software clears out_packet_ready and matters only in iso mode.
// - Control-high bit 7 enables double buffering of the receive endpoint.
// - Control-high bit 6 selects isochronous (1) or bulk/interrupt (0) transfers.
// - Count-low reports the lower eight bits of the last received packet length.
// - Count-high bits 1:0 report the upper two bits of that length, other bits zero.
// - Endpoint registers are reached by address port then data port.
// - Configuration bit 6 lets bus-power events raise the interrupt.
// - Clock select 0 picks high-frequency oscillator one, 1 picks it divided by eight.
// - Clock select 2 to 5 pick the external oscillator divided by 1 to 4.
// - Clock select 6 picks the low-frequency oscillator, 7 (reset) turns the clock off.
module uoe_top
	import uoe_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_addr,
	input wire logic [7:0] i_sfr_wdata,
	input wire uoe_rx_pkt_t i_rx_pkt,
	input wire logic i_bus_power_pin,
	input wire logic i_irq_ctrl_enable,
	input wire logic i_low_energy_active,
	output logic [7:0] o_sfr_rdata,
	output logic o_irq,
	output logic o_rx_fifo_full,
	output logic o_usb_tick,
	output logic [3:0] o_usb_clk_source
);
	uoe_state_t s_q;
	uoe_state_t s_d;
	logic full;
	logic sense_rise;
	logic [7:0] ctrl_low;
	logic [2:0] div_max;

	// ****************************************
	// Functions
	// ****************************************
	// Two slots with double buffering, otherwise one
	function automatic logic fifo_is_full(input logic dbl, input logic [1:0] pkts);
		return dbl ? (pkts == 2'd2) : (pkts != 2'd0);
	endfunction

	// ****************************************
	// Combinational next state
	// ****************************************
	always_comb
	begin
		s_d = s_q;
		full = fifo_is_full(s_q.dbl, s_q.pkts);
		ctrl_low = 8'h00;
		ctrl_low[UOE_BIT_OUT_PACKET_READY] = s_q.out_packet_ready;
		ctrl_low[UOE_BIT_FULL] = full;
		ctrl_low[UOE_BIT_OVR] = s_q.ovr;
		ctrl_low[UOE_BIT_ERR] = s_q.err;
		// Pin passes two flops; first stage read only by the second
		s_d.sense_sync = {s_q.sense_sync[0], i_bus_power_pin};
		s_d.sense_prev = s_q.sense_sync[1];
		sense_rise = s_q.sense_en && s_q.sense_sync[1] && !s_q.sense_prev;

		// ****************************************
		// Software writes: address port, data port, configuration
		// ****************************************
		if (i_sfr_wr)
		begin
			unique case (i_sfr_addr)
				// Index holds, so repeated data-port accesses hit one register
				UOE_SFR_ADDR_PORT: s_d.addr = i_sfr_wdata;
				UOE_SFR_DATA_PORT:
				begin
					if (s_q.addr == UOE_IDX_CTRL_HIGH)
					begin
						s_d.dbl = i_sfr_wdata[UOE_BIT_DBL];
						s_d.iso = i_sfr_wdata[UOE_BIT_ISO];
					end
					else if (s_q.addr == UOE_IDX_CTRL_LOW)
					begin
						if (s_q.out_packet_ready && !i_sfr_wdata[UOE_BIT_OUT_PACKET_READY])
						begin
							// A second waiting packet is ready at once
							s_d.out_packet_ready = (s_q.pkts == 2'd2);
							s_d.err = 1'b0;
							if (s_q.pkts != 2'd0)
								s_d.pkts = s_q.pkts - 2'd1;
						end
						if (!i_sfr_wdata[UOE_BIT_OVR])
							s_d.ovr = 1'b0;
					end
				end
				UOE_SFR_CONFIG:
				begin
					s_d.sense_en = i_sfr_wdata[UOE_BIT_SENSE_EN];
					s_d.irq_en = i_sfr_wdata[UOE_BIT_IRQ_EN];
					if (!i_sfr_wdata[UOE_BIT_EVENT])
						s_d.event_flag = 1'b0;
					s_d.clksel = i_sfr_wdata[2:0];
				end
				default: ;
			endcase
		end

		// ****************************************
		// Hardware events after software so that a set wins over a clear
		// ****************************************
		if (i_rx_pkt.done)
		begin
			if (full)
			begin
				// Bulk packets are refused by handshake, so only iso loses data
				if (s_q.iso)
					s_d.ovr = 1'b1;
			end
			else
			begin
				s_d.pkts = s_d.pkts + 2'd1;
				s_d.out_packet_ready = 1'b1;
				s_d.count = i_rx_pkt.count;
				if (s_q.iso && (i_rx_pkt.crc_err || i_rx_pkt.stuff_err))
					s_d.err = 1'b1;
			end
		end
		if (sense_rise)
			s_d.event_flag = 1'b1;
		s_d.irq = s_d.event_flag && s_d.irq_en && i_irq_ctrl_enable;
		s_d.fifo_full = fifo_is_full(s_d.dbl, s_d.pkts);

		// ****************************************
		// Clock source choice and divider enable
		// ****************************************
		unique case (uoe_clksel_t'(s_q.clksel))
			UOE_CLK_HF: s_d.src_en = 4'b0001;
			UOE_CLK_HF_DIV8: s_d.src_en = 4'b0001;
			UOE_CLK_EXT_DIV1, UOE_CLK_EXT_DIV2,
			UOE_CLK_EXT_DIV3, UOE_CLK_EXT_DIV4: s_d.src_en = 4'b0010;
			UOE_CLK_LF: s_d.src_en = 4'b0100;
			UOE_CLK_OFF: s_d.src_en = 4'b0000;
		endcase
		unique case (uoe_clksel_t'(s_q.clksel))
			UOE_CLK_HF_DIV8: div_max = 3'd7;
			UOE_CLK_EXT_DIV2: div_max = 3'd1;
			UOE_CLK_EXT_DIV3: div_max = 3'd2;
			UOE_CLK_EXT_DIV4: div_max = 3'd3;
			UOE_CLK_HF, UOE_CLK_EXT_DIV1,
			UOE_CLK_LF, UOE_CLK_OFF: div_max = 3'd0;
		endcase
		// Tick stands in for the divided USB clock as an enable
		if (s_q.clksel == UOE_CLKSEL_RESET)
		begin
			s_d.div_cnt = 3'd0;
			s_d.usb_tick = 1'b0;
		end
		else if (s_q.div_cnt >= div_max)
		begin
			s_d.div_cnt = 3'd0;
			s_d.usb_tick = 1'b1;
		end
		else
		begin
			s_d.div_cnt = s_q.div_cnt + 3'd1;
			s_d.usb_tick = 1'b0;
		end

		// ****************************************
		// Read data, registered one cycle after the strobe
		// ****************************************
		s_d.rdata = 8'h00;
		if (i_sfr_rd)
		begin
			unique case (i_sfr_addr)
				UOE_SFR_ADDR_PORT: s_d.rdata = s_q.addr;
				UOE_SFR_DATA_PORT:
				begin
					unique case (s_q.addr)
						UOE_IDX_CTRL_LOW: s_d.rdata = ctrl_low;
						UOE_IDX_CTRL_HIGH: s_d.rdata = {s_q.dbl, s_q.iso, 6'h00};
						UOE_IDX_COUNT_LOW: s_d.rdata = s_q.count[7:0];
						UOE_IDX_COUNT_HIGH: s_d.rdata = {6'h00, s_q.count[9:8]};
						default: s_d.rdata = 8'h00;
					endcase
				end
				UOE_SFR_CONFIG:
					s_d.rdata = {s_q.sense_en, s_q.irq_en, s_q.event_flag, 2'b00, s_q.clksel};
				UOE_SFR_ENERGY: s_d.rdata = {i_low_energy_active, 7'h00};
				default: s_d.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			s_q <= '0;
			// USB clock stays off until software picks a source
			s_q.clksel <= UOE_CLKSEL_RESET;
		end
		else
			s_q <= s_d;
	end

	// ****************************************
	// Outputs, each straight from the state register
	// ****************************************
	assign o_sfr_rdata = s_q.rdata;
	assign o_irq = s_q.irq;
	assign o_rx_fifo_full = s_q.fifo_full;
	assign o_usb_tick = s_q.usb_tick;
	assign o_usb_clk_source = s_q.src_en;
endmodule

// File: tb/uoe_props.sv
`timescale 1ns/100ps
module uoe_props
	import uoe_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire uoe_rx_pkt_t i_rx_pkt,
	input wire logic i_irq_ctrl_enable,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_irq,
	input wire logic o_rx_fifo_full,
	input wire logic o_usb_tick,
	input wire logic [3:0] o_usb_clk_source
);
	default clocking @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	irq_gate_a: assert property (!i_irq_ctrl_enable |=> !o_irq)
		else $error("irq while masked");
	rd_idle_a: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00)
		else $error("data without read");
	src_onehot_a: assert property ($onehot0(o_usb_clk_source) && (!o_usb_tick || o_usb_clk_source != 4'h0))
		else $error("two sources");
	off_quiet_a: assert property ((o_usb_clk_source == 4'h0) [*3] |-> !o_usb_tick)
		else $error("tick while off");
	lf_tick_a: assert property (o_usb_clk_source[2] [*3] |-> o_usb_tick)
		else $error("slow source missed tick");
	hf_gap_a: assert property (o_usb_tick && o_usb_clk_source[0] |-> ##[1:8] o_usb_tick)
		else $error("tick gap too long");
	full_rise_a: assert property ($rose(o_rx_fifo_full) |-> $past(i_rx_pkt.done || i_sfr_wr))
		else $error("full without cause");
	full_fall_a: assert property ($fell(o_rx_fifo_full) |-> $past(i_sfr_wr))
		else $error("full dropped alone");
endmodule

// File: tb/uoe_host_model.sv
`timescale 1ns/100ps
module uoe_host_model
	import uoe_pkg::*;
(
	input wire logic i_clock,
	output uoe_rx_pkt_t o_pkt
);
	initial o_pkt = '0;
	// Count is not held after the packet, so show its inverse
	task send(input logic [9:0] n, input logic crc, input logic stuff);
		@(posedge i_clock);
		o_pkt <= '{1'b1, crc, stuff, n};
		@(posedge i_clock);
		o_pkt <= '{1'b0, 1'b0, 1'b0, ~n};
	endtask
endmodule

// File: tb/usb_out_endpoint_and_config_regs_test.sv
`timescale 1ns/100ps
module usb_out_endpoint_and_config_regs_test;
	import uoe_pkg::*;
	localparam logic [7:0] LO = UOE_IDX_CTRL_LOW;
	localparam logic [7:0] CF = UOE_SFR_CONFIG;
	logic i_clock = 0, i_reset_n = 0, wr = 0, rd = 0, pin = 0, ien = 0, lea = 1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	logic irq, full, tick;
	logic [3:0] src;
	uoe_rx_pkt_t pkt;
	int n_mismatch = 0, n_compared = 0;
	uoe_top uoe_top_inst (.i_clock, .i_reset_n, .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_addr(addr),
		.i_sfr_wdata(wdata), .i_rx_pkt(pkt), .i_bus_power_pin(pin), .i_irq_ctrl_enable(ien),
		.i_low_energy_active(lea), .o_sfr_rdata(rdata), .o_irq(irq), .o_rx_fifo_full(full),
		.o_usb_tick(tick), .o_usb_clk_source(src));
	uoe_host_model uoe_host_model_inst (.i_clock, .o_pkt(pkt));
	initial forever #5 i_clock = ~i_clock;
	task stop_test;
		if (n_mismatch == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] e, input logic [7:0] got);
		n_compared++;
		if (got !== e)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, e, got);
		end
	endtask
	task ws(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge i_clock);
		wr <= 1'b0;
	endtask
	task rs(input logic [7:0] a, input logic [7:0] e, input string what);
		@(posedge i_clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge i_clock);
		rd <= 1'b0;
		#1 chk(what, e, rdata);
	endtask
	task iw(input logic [7:0] i, input logic [7:0] d);
		ws(UOE_SFR_ADDR_PORT, i);
		ws(UOE_SFR_DATA_PORT, d);
	endtask
	task ir(input logic [7:0] i, input logic [7:0] e, input string what);
		ws(UOE_SFR_ADDR_PORT, i);
		rs(UOE_SFR_DATA_PORT, e, what);
	endtask
	task pk(input logic [9:0] n, input logic crc, input logic stuff);
		uoe_host_model_inst.send(n, crc, stuff);
	endtask
	task t_reset;
		ir(UOE_IDX_CTRL_HIGH, 8'h00, "ctl_hi");
		ir(UOE_IDX_COUNT_HIGH, 8'h00, "cnt_hi");
		rs(CF, 8'h07, "config");
		rs(UOE_SFR_ENERGY, 8'h80, "energy");
		rs(8'h33, 8'h00, "unmapped");
	endtask
	task t_iso;
		iw(UOE_IDX_CTRL_HIGH, 8'h40);
		ir(UOE_IDX_CTRL_HIGH, 8'h40, "ctl_hi");
		pk(10'h2a5, 1'b1, 1'b0);
		ir(LO, 8'h0b, "ctl_lo");
		ir(UOE_IDX_COUNT_LOW, 8'ha5, "cnt_lo");
		ir(UOE_IDX_COUNT_HIGH, 8'h02, "cnt_hi");
		pk(10'h011, 1'b0, 1'b0);
		ir(LO, 8'h0f, "ctl_lo");
		iw(LO, 8'h04);
		ir(LO, 8'h04, "ctl_lo");
		iw(LO, 8'h00);
		pk(10'h011, 1'b0, 1'b1);
		ir(LO, 8'h0b, "ctl_lo");
		iw(LO, 8'h00);
	endtask
	task t_bulk;
		iw(UOE_IDX_CTRL_HIGH, 8'h80);
		pk(10'h3ff, 1'b1, 1'b1);
		pk(10'h001, 1'b0, 1'b0);
		pk(10'h002, 1'b0, 1'b0);
		ir(LO, 8'h03, "ctl_lo");
		chk("full", 8'h01, {7'h00, full});
		ir(UOE_IDX_COUNT_LOW, 8'h01, "cnt_lo");
		iw(LO, 8'h00);
		ir(LO, 8'h01, "ctl_lo");
		iw(LO, 8'h00);
		ir(LO, 8'h00, "ctl_lo");
	endtask
	task t_power;
		ws(CF, 8'h47);
		@(posedge i_clock);
		pin <= 1'b1;
		rs(CF, 8'h47, "config");
		@(posedge i_clock);
		pin <= 1'b0;
		ien <= 1'b1;
		ws(CF, 8'hc7);
		@(posedge i_clock);
		pin <= 1'b1;
		repeat (6) @(posedge i_clock);
		#1 chk("irq", 8'h01, {7'h00, irq});
		@(posedge i_clock);
		ien <= 1'b0;
		@(posedge i_clock);
		#1 chk("irq", 8'h00, {7'h00, irq});
		@(posedge i_clock);
		ien <= 1'b1;
		rs(CF, 8'he7, "config");
		ws(CF, 8'he7);
		rs(CF, 8'he7, "config");
		ws(CF, 8'hc7);
		rs(CF, 8'hc7, "config");
		chk("irq", 8'h00, {7'h00, irq});
	endtask
	task t_clock;
		int n;
		int et[8] = '{24, 3, 24, 12, 8, 6, 24, 0};
		logic [3:0] e;
		for (int c = 0; c < 8; c++)
		begin
			ws(CF, 8'(c));
			e = (c < 2) ? 4'h1 : (c < 6) ? 4'h2 : (c == 6) ? 4'h4 : 4'h0;
			n = 0;
			repeat (4) @(posedge i_clock);
			#1 chk("source", {4'h0, e}, {4'h0, src});
			repeat (24) @(posedge i_clock) #1 n += tick;
			chk("ticks", 8'(et[c]), 8'(n));
		end
	endtask
	initial
	begin
		repeat (6) @(posedge i_clock);
		i_reset_n <= 1'b1;
		t_reset;
		t_iso;
		t_power;
		t_clock;
		t_bulk;
		stop_test;
	end
	initial
	begin
		#200000;
		n_mismatch++;
		stop_test;
	end
endmodule
bind uoe_top uoe_props uoe_props_inst (.i_clock, .i_reset_n, .i_sfr_wr, .i_sfr_rd, .i_rx_pkt,
	.i_irq_ctrl_enable, .o_sfr_rdata, .o_irq, .o_rx_fifo_full, .o_usb_tick, .o_usb_clk_source);
